//--- sobc_defines.svh
// Register map, field positions, reset values and line constants
`ifndef SOBC_DEFINES_SVH
`define SOBC_DEFINES_SVH
`define SOBC_IDX_MODE        8'h00
`define SOBC_IDX_EVENT       8'h01
`define SOBC_IDX_DIAG        8'h19
`define SOBC_IDX_TX_Z1       8'h1A
`define SOBC_IDX_Z1_Z0       8'h1B
`define SOBC_IDX_K1_AIS      8'h1D
`define SOBC_IDX_K2_RDI      8'h1E
`define SOBC_MODE_ENH        0
`define SOBC_MODE_SECONDARY_IDENT_INSERT_ENABLE      1
`define SOBC_MODE_Z1IE       2
`define SOBC_MODE_APSIE      3
`define SOBC_MODE_RING       4
`define SOBC_MODE_STS3       5
`define SOBC_DIAG_PARITY     1
`define SOBC_DIAG_FZERO      2
`define SOBC_EVT_Z1          0
`define SOBC_EVT_APS         1
`define SOBC_CTL_SD          7
`define SOBC_CTL_SF          6
`define SOBC_CTL_LOF         5
`define SOBC_CTL_LOS         4
`define SOBC_CTL_TIM         3
`define SOBC_CTL_TIU         2
`define SOBC_CTL_AIS         1
`define SOBC_CTL_DCC         0
`define SOBC_RST_MODE        8'h00
`define SOBC_RST_DIAG        8'h00
`define SOBC_RST_TX_Z1       8'h00
`define SOBC_RST_TX_Z0       8'hCC
`define SOBC_RST_AIS_CTL     8'h30
`define SOBC_RST_RDI_CTL     8'h32
`define SOBC_AIS_CTL_MASK    8'hFD
`define SOBC_RDI_CTL_MASK    8'hFE
`define SOBC_K_PERSIST       2'd3
`define SOBC_TRACE_UNSTABLE  4'd8
`define SOBC_RDI_CODE        3'b110
`define SOBC_ALL_ONES        8'hFF
`define SOBC_ALL_ZEROS       8'h00
`endif

//--- sobc_pkg.sv
// Types for the overhead byte control block
package sobc_pkg;
    typedef enum logic [2:0] {
        SOBC_TX_OTHER, SOBC_TX_B1, SOBC_TX_Z1_FIRST, SOBC_TX_Z1_OTHER,
        SOBC_TX_Z0_OTHER, SOBC_TX_K2
    } sobc_tx_pos_t;
    typedef enum logic [2:0] {
        SOBC_RX_OTHER, SOBC_RX_SOH, SOBC_RX_Z1_FIRST, SOBC_RX_K1, SOBC_RX_K2
    } sobc_rx_pos_t;
    typedef enum logic {
        SOBC_TRC_STABLE, SOBC_TRC_UNSTABLE
    } sobc_trc_state_t;
endpackage : sobc_pkg

//--- sobc_overhead_ctrl.sv
// Overhead byte insertion, extraction and alarm fill with APB registers
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`include "sobc_defines.svh"
module sobc_overhead_ctrl
    import sobc_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic         tx_in_valid,
    input  wire logic [7:0]   tx_in_data,
    input  wire sobc_tx_pos_t tx_in_pos,
    input  wire logic [7:0]   tx_b1_calc,
    input  wire logic         tx_overhead_port_enable,
    input  wire logic [7:0]   tx_overhead_data,
    input  wire logic         tx_passthrough_select,
    output logic [7:0]        tx_parallel_out,
    output logic              tx_out_valid,
    output logic              tx_serial_out,
    input  wire logic         rx_in_valid,
    input  wire logic [7:0]   rx_in_data,
    input  wire sobc_rx_pos_t rx_in_pos,
    input  wire logic         rx_section_dcc_in,
    input  wire logic         rx_line_dcc_in,
    output logic [7:0]        rx_parallel_out,
    output logic              rx_out_valid,
    output logic              rx_section_dcc_out,
    output logic              rx_line_dcc_out,
    input  wire logic         los_declared,
    input  wire logic         lof_declared,
    input  wire logic         sf_declared,
    input  wire logic         sd_declared,
    input  wire logic         line_ais_detected,
    input  wire logic         trace_mismatch,
    input  wire logic         trace_msg_done,
    input  wire logic         trace_msg_matches_prev,
    input  wire logic         trace_msg_accepted,
    output logic              tx_rdi_active,
    output logic              rx_ring_send_rdi,
    output logic              rx_ais_active,
    output logic              irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state
    logic [7:0]      mode_ff;
    logic [7:0]      diag_ff;
    logic [7:0]      tx_z1_ff;
    logic [7:0]      tx_z0_ff;
    logic [7:0]      ais_ctl_ff;
    logic [7:0]      rdi_ctl_ff;
    logic [1:0]      event_ff;
    logic [7:0]      rx_z1_ff;
    logic            rx_z1_seen_ff;
    logic [7:0]      k_cur_ff  [2];
    logic [7:0]      k_cand_ff [2];
    logic [1:0]      k_cnt_ff  [2];
    logic [1:0]      k_accept;
    logic [31:0]     prdata_ff;
    logic [7:0]      tx_out_ff;
    logic            tx_valid_ff;
    logic [7:0]      tx_shift_ff;
    logic [7:0]      rx_out_ff;
    logic            rx_valid_ff;
    logic            sdcc_ff;
    logic            ldcc_ff;
    logic [3:0]      trc_cnt_ff;
    sobc_trc_state_t trc_state_ff;
    sobc_trc_state_t nxt_trc_state;

    logic            enhanced_map_select;
    logic            wr_en;
    logic            rd_setup;
    logic [7:0]      idx;
    logic            z1_change;
    logic            ais_ins;
    logic            rdi_ins;
    logic            dcc_fill;
    logic [7:0]      nxt_tx_byte;
    logic [7:0]      nxt_rx_byte;
    logic [7:0]      rd_byte;

    ////////////////////////////////////////////////////////////////////////////
    // Register decode
    function automatic logic idx_mapped(input logic [7:0] addr);
        logic [7:0] i;
        i = {2'b00, addr[7:2]};
        idx_mapped = (addr[1:0] == 2'b00) &&
                     (i == `SOBC_IDX_MODE   || i == `SOBC_IDX_EVENT  ||
                      i == `SOBC_IDX_DIAG   || i == `SOBC_IDX_TX_Z1  ||
                      i == `SOBC_IDX_Z1_Z0  || i == `SOBC_IDX_K1_AIS ||
                      i == `SOBC_IDX_K2_RDI);
    endfunction : idx_mapped

    assign idx      = {2'b00, paddr[7:2]};
    assign enhanced_map_select      = mode_ff[`SOBC_MODE_ENH];
    assign wr_en    = psel && penable && pwrite && idx_mapped(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !idx_mapped(paddr);
    assign prdata   = prdata_ff;

    // Read mux; 1B/1D/1E swap meaning with the enhanced map
    always_comb
    begin
        rd_byte = `SOBC_ALL_ZEROS;
        case (idx)
            `SOBC_IDX_MODE:   rd_byte = mode_ff;
            `SOBC_IDX_EVENT:  rd_byte = {6'b000000, event_ff};
            `SOBC_IDX_DIAG:   rd_byte = diag_ff;
            `SOBC_IDX_TX_Z1:  rd_byte = tx_z1_ff;
            `SOBC_IDX_Z1_Z0:  rd_byte = enhanced_map_select ? tx_z0_ff : rx_z1_ff;
            `SOBC_IDX_K1_AIS: rd_byte = enhanced_map_select ? ais_ctl_ff : k_cur_ff[0];
            `SOBC_IDX_K2_RDI: rd_byte = enhanced_map_select ? rdi_ctl_ff : k_cur_ff[1];
            default:          rd_byte = `SOBC_ALL_ZEROS;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_ff <= 32'h0000_0000;
        else if (rd_setup)
            prdata_ff <= idx_mapped(paddr) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software-written registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_ff    <= `SOBC_RST_MODE;
            diag_ff    <= `SOBC_RST_DIAG;
            tx_z1_ff   <= `SOBC_RST_TX_Z1;
            tx_z0_ff   <= `SOBC_RST_TX_Z0;
            ais_ctl_ff <= `SOBC_RST_AIS_CTL;
            rdi_ctl_ff <= `SOBC_RST_RDI_CTL;
        end
        else if (wr_en)
        begin
            case (idx)
                `SOBC_IDX_MODE:   mode_ff  <= pwdata[7:0];
                `SOBC_IDX_DIAG:   diag_ff  <= pwdata[7:0];
                `SOBC_IDX_TX_Z1:  tx_z1_ff <= pwdata[7:0];
                `SOBC_IDX_Z1_Z0:
                begin
                    if (enhanced_map_select)
                        tx_z0_ff <= pwdata[7:0];
                end
                `SOBC_IDX_K1_AIS:
                begin
                    if (enhanced_map_select)
                        ais_ctl_ff <= pwdata[7:0] & `SOBC_AIS_CTL_MASK;
                end
                `SOBC_IDX_K2_RDI:
                begin
                    if (enhanced_map_select)
                        rdi_ctl_ff <= pwdata[7:0] & `SOBC_RDI_CTL_MASK;
                end
                default:
                begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event flags, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            event_ff <= 2'b00;
        else
        begin
            for (int b = 0; b < 2; b++)
            begin
                if ((b == `SOBC_EVT_Z1) ? z1_change : (|k_accept))
                    event_ff[b] <= 1'b1;
                else if (wr_en && idx == `SOBC_IDX_EVENT && pwdata[b])
                    event_ff[b] <= 1'b0;
            end
        end
    end

    assign irq = (event_ff[`SOBC_EVT_Z1] && mode_ff[`SOBC_MODE_Z1IE]) ||
                 (event_ff[`SOBC_EVT_APS] && mode_ff[`SOBC_MODE_APSIE]);

    ////////////////////////////////////////////////////////////////////////////
    // Transmit overhead insertion
    always_comb
    begin
        nxt_tx_byte = tx_in_data;
        if (tx_overhead_port_enable)
            nxt_tx_byte = tx_overhead_data;
        else if (!tx_passthrough_select)
        begin
            case (tx_in_pos)
                SOBC_TX_B1:
                    nxt_tx_byte = diag_ff[`SOBC_DIAG_PARITY] ? ~tx_b1_calc
                                                            : tx_b1_calc;
                SOBC_TX_Z1_FIRST:
                    nxt_tx_byte = tx_z1_ff;
                SOBC_TX_Z1_OTHER:
                    nxt_tx_byte = mode_ff[`SOBC_MODE_STS3] ? `SOBC_ALL_ZEROS
                                                           : tx_in_data;
                SOBC_TX_Z0_OTHER:
                    nxt_tx_byte = (enhanced_map_select && mode_ff[`SOBC_MODE_SECONDARY_IDENT_INSERT_ENABLE]) ? tx_z0_ff
                                                                      : tx_in_data;
                SOBC_TX_K2:
                    nxt_tx_byte = (rdi_ins && !mode_ff[`SOBC_MODE_RING])
                                  ? {tx_in_data[7:3], `SOBC_RDI_CODE}
                                  : tx_in_data;
                default:
                    nxt_tx_byte = tx_in_data;
            endcase
        end
        if (diag_ff[`SOBC_DIAG_FZERO])
            nxt_tx_byte = `SOBC_ALL_ZEROS;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_out_ff   <= `SOBC_ALL_ZEROS;
            tx_valid_ff <= 1'b0;
        end
        else
        begin
            tx_valid_ff <= tx_in_valid;
            if (diag_ff[`SOBC_DIAG_FZERO])
                tx_out_ff <= `SOBC_ALL_ZEROS;
            else if (tx_in_valid)
                tx_out_ff <= nxt_tx_byte;
        end
    end

    // Serial shifter, bit 7 leaves first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_shift_ff <= `SOBC_ALL_ZEROS;
        else if (diag_ff[`SOBC_DIAG_FZERO])
            tx_shift_ff <= `SOBC_ALL_ZEROS;
        else if (tx_in_valid)
            tx_shift_ff <= nxt_tx_byte;
        else
            tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
    end

    assign tx_parallel_out = tx_out_ff;
    assign tx_out_valid    = tx_valid_ff;
    assign tx_serial_out   = tx_shift_ff[7];

    ////////////////////////////////////////////////////////////////////////////
    // Receive Z1 capture and change detect
    assign z1_change = rx_in_valid && (rx_in_pos == SOBC_RX_Z1_FIRST) && !enhanced_map_select &&
                       rx_z1_seen_ff && (rx_in_data != rx_z1_ff);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_z1_ff      <= `SOBC_ALL_ZEROS;
            rx_z1_seen_ff <= 1'b0;
        end
        else if (rx_in_valid && rx_in_pos == SOBC_RX_Z1_FIRST && !enhanced_map_select)
        begin
            rx_z1_ff      <= rx_in_data;
            rx_z1_seen_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // K1 and K2 three-frame persistence
    generate
        for (genvar k = 0; k < 2; k++)
        begin : g_kbyte
            sobc_rx_pos_t kpos;
            logic         hit;
            assign kpos = (k == 0) ? SOBC_RX_K1 : SOBC_RX_K2;
            assign hit  = rx_in_valid && (rx_in_pos == kpos) && !enhanced_map_select;
            assign k_accept[k] = hit && (rx_in_data != k_cur_ff[k]) &&
                                 (rx_in_data == k_cand_ff[k]) &&
                                 (k_cnt_ff[k] == `SOBC_K_PERSIST - 2'd1);

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    k_cur_ff[k]  <= `SOBC_ALL_ZEROS;
                    k_cand_ff[k] <= `SOBC_ALL_ZEROS;
                    k_cnt_ff[k]  <= 2'd0;
                end
                else if (hit)
                begin
                    if (rx_in_data == k_cur_ff[k])
                        k_cnt_ff[k] <= 2'd0;
                    else if (k_accept[k])
                    begin
                        k_cur_ff[k] <= rx_in_data;
                        k_cnt_ff[k] <= 2'd0;
                    end
                    else if (rx_in_data == k_cand_ff[k] && k_cnt_ff[k] != 2'd0)
                        k_cnt_ff[k] <= k_cnt_ff[k] + 2'd1;
                    else
                    begin
                        k_cand_ff[k] <= rx_in_data;
                        k_cnt_ff[k]  <= 2'd1;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Trace unstable tracker
    always_comb
    begin
        nxt_trc_state = trc_state_ff;
        case (trc_state_ff)
            SOBC_TRC_STABLE:
                if (trace_msg_done && !trace_msg_matches_prev &&
                    trc_cnt_ff == `SOBC_TRACE_UNSTABLE - 4'd1)
                    nxt_trc_state = SOBC_TRC_UNSTABLE;
            SOBC_TRC_UNSTABLE:
                if (trace_msg_accepted)
                    nxt_trc_state = SOBC_TRC_STABLE;
            default:
                nxt_trc_state = SOBC_TRC_STABLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trc_state_ff <= SOBC_TRC_STABLE;
            trc_cnt_ff   <= 4'd0;
        end
        else
        begin
            trc_state_ff <= nxt_trc_state;
            if (trace_msg_accepted || (trace_msg_done && trace_msg_matches_prev))
                trc_cnt_ff <= 4'd0;
            else if (trace_msg_done && trc_cnt_ff != `SOBC_TRACE_UNSTABLE)
                trc_cnt_ff <= trc_cnt_ff + 4'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Alarm-driven AIS, RDI and DCC fill
    assign ais_ins = enhanced_map_select && (
        (ais_ctl_ff[`SOBC_CTL_TIU] && trc_state_ff == SOBC_TRC_UNSTABLE) ||
        (ais_ctl_ff[`SOBC_CTL_TIM] && trace_mismatch) ||
        (ais_ctl_ff[`SOBC_CTL_LOS] && los_declared) ||
        (ais_ctl_ff[`SOBC_CTL_LOF] && lof_declared) ||
        (ais_ctl_ff[`SOBC_CTL_SF]  && sf_declared) ||
        (ais_ctl_ff[`SOBC_CTL_SD]  && sd_declared));

    assign rdi_ins = enhanced_map_select && (
        (rdi_ctl_ff[`SOBC_CTL_AIS] && line_ais_detected) ||
        (rdi_ctl_ff[`SOBC_CTL_SD]  && sd_declared) ||
        (rdi_ctl_ff[`SOBC_CTL_SF]  && sf_declared) ||
        (rdi_ctl_ff[`SOBC_CTL_LOF] && lof_declared) ||
        (rdi_ctl_ff[`SOBC_CTL_LOS] && los_declared) ||
        (rdi_ctl_ff[`SOBC_CTL_TIM] && trace_mismatch) ||
        (rdi_ctl_ff[`SOBC_CTL_TIU] && trc_state_ff == SOBC_TRC_UNSTABLE));

    assign dcc_fill = ais_ctl_ff[`SOBC_CTL_DCC] && (lof_declared || los_declared);

    assign nxt_rx_byte = (ais_ins && rx_in_pos != SOBC_RX_SOH &&
                          rx_in_pos != SOBC_RX_Z1_FIRST) ? `SOBC_ALL_ONES
                                                         : rx_in_data;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_out_ff   <= `SOBC_ALL_ZEROS;
            rx_valid_ff <= 1'b0;
            sdcc_ff     <= 1'b0;
            ldcc_ff     <= 1'b0;
        end
        else
        begin
            rx_valid_ff <= rx_in_valid;
            if (rx_in_valid)
                rx_out_ff <= nxt_rx_byte;
            sdcc_ff <= dcc_fill | rx_section_dcc_in;
            ldcc_ff <= dcc_fill | rx_line_dcc_in;
        end
    end

    assign rx_parallel_out    = rx_out_ff;
    assign rx_out_valid       = rx_valid_ff;
    assign rx_section_dcc_out = sdcc_ff;
    assign rx_line_dcc_out    = ldcc_ff;
    assign rx_ais_active      = ais_ins;
    assign tx_rdi_active      = rdi_ins && !mode_ff[`SOBC_MODE_RING];
    assign rx_ring_send_rdi   = rdi_ins && mode_ff[`SOBC_MODE_RING];

endmodule : sobc_overhead_ctrl

//--- sobc_overhead_ctrl_checker.sv
// Port-level assertions for the overhead byte control block
`timescale 1ns/10ps
module sobc_overhead_ctrl_checker
    import sobc_pkg::*;
(
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pready,
    input wire logic         pslverr,
    input wire logic         tx_in_valid,
    input wire logic         tx_overhead_port_enable,
    input wire logic [7:0]   tx_overhead_data,
    input wire logic [7:0]   tx_parallel_out,
    input wire logic         tx_out_valid,
    input wire logic         tx_serial_out,
    input wire logic         rx_in_valid,
    input wire logic [7:0]   rx_in_data,
    input wire sobc_rx_pos_t rx_in_pos,
    input wire logic [7:0]   rx_parallel_out,
    input wire logic         rx_ais_active,
    input wire logic         los_declared,
    input wire logic         lof_declared,
    input wire logic         rx_section_dcc_in,
    input wire logic         rx_section_dcc_out
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_tx_answer;
        ##1 tx_out_valid;
    endsequence
    sequence s_rx_fill_cause;
        rx_in_valid && rx_ais_active && (rx_in_pos inside {SOBC_RX_OTHER, SOBC_RX_K1, SOBC_RX_K2});
    endsequence
    property p_pready;
        psel && penable |-> pready;
    endproperty
    property p_err;
        pslverr |-> psel && penable;
    endproperty
    property p_tx_lat;
        tx_in_valid |-> s_tx_answer;
    endproperty
    property p_tx_port;
        tx_in_valid && tx_overhead_port_enable
            |=> tx_parallel_out == $past(tx_overhead_data) || tx_parallel_out == 8'h00;
    endproperty
    property p_tx_msb;
        tx_out_valid |-> tx_serial_out == tx_parallel_out[7];
    endproperty
    property p_rx_soh;
        rx_in_valid && rx_in_pos == SOBC_RX_SOH |=> rx_parallel_out == $past(rx_in_data);
    endproperty
    property p_rx_fill;
        s_rx_fill_cause |=> rx_parallel_out == 8'hFF;
    endproperty
    property p_dcc;
        !los_declared && !lof_declared |=> rx_section_dcc_out == $past(rx_section_dcc_in);
    endproperty
    a_pready: assert property (p_pready) else $error("access without ready");
    a_err: assert property (p_err) else $error("error outside access");
    a_tx_lat: assert property (p_tx_lat) else $error("tx byte not answered");
    a_tx_port: assert property (p_tx_port) else $error("port byte lost");
    a_tx_msb: assert property (p_tx_msb) else $error("serial not msb first");
    a_rx_soh: assert property (p_rx_soh) else $error("section byte altered");
    a_rx_fill: assert property (p_rx_fill) else $error("alarm fill missing");
    a_dcc: assert property (p_dcc) else $error("dcc forced without alarm");
endmodule : sobc_overhead_ctrl_checker
bind sobc_overhead_ctrl sobc_overhead_ctrl_checker u_checker (.*);

//--- sobc_line_model.sv
// Line-side partner driving the transmit and receive byte streams
`timescale 1ns/10ps
module sobc_line_model
    import sobc_pkg::*;
(
    input  wire logic    pclk,
    output logic         tx_in_valid,
    output logic [7:0]   tx_in_data,
    output sobc_tx_pos_t tx_in_pos,
    output logic         rx_in_valid,
    output logic [7:0]   rx_in_data,
    output sobc_rx_pos_t rx_in_pos
);
    initial
    begin
        {tx_in_valid, tx_in_data, rx_in_valid, rx_in_data} = '0;
        tx_in_pos = SOBC_TX_OTHER;
        rx_in_pos = SOBC_RX_OTHER;
    end
    task automatic send_tx(input sobc_tx_pos_t p, input logic [7:0] d);
        @(posedge pclk);
        tx_in_valid <= 1'b1;
        tx_in_pos   <= p;
        tx_in_data  <= d;
        @(posedge pclk);
        tx_in_valid <= 1'b0;
        tx_in_data  <= ~d;
    endtask : send_tx
    task automatic send_rx(input sobc_rx_pos_t p, input logic [7:0] d);
        @(posedge pclk);
        rx_in_valid <= 1'b1;
        rx_in_pos   <= p;
        rx_in_data  <= d;
        @(posedge pclk);
        rx_in_valid <= 1'b0;
        rx_in_data  <= ~d;
    endtask : send_rx
endmodule : sobc_line_model

//--- sobc_overhead_ctrl_tb.sv
// Self-checking bench for the overhead byte control block
`timescale 1ns/10ps
`include "sobc_defines.svh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module sobc_overhead_ctrl_tb
    import sobc_pkg::*;
;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0]   paddr, rd, tx_b1_calc, tx_overhead_data, tx_parallel_out, rx_parallel_out;
    logic [31:0]  pwdata, prdata;
    logic         tx_out_valid, tx_serial_out, rx_out_valid, rx_section_dcc_out, rx_line_dcc_out;
    logic         tx_rdi_active, rx_ring_send_rdi, rx_ais_active, tx_in_valid, rx_in_valid;
    logic [7:0]   tx_in_data, rx_in_data;
    sobc_tx_pos_t tx_in_pos;
    sobc_rx_pos_t rx_in_pos;
    logic         tx_overhead_port_enable, tx_passthrough_select, rx_section_dcc_in;
    logic         rx_line_dcc_in, los_declared, lof_declared, sf_declared, sd_declared;
    logic         line_ais_detected, trace_mismatch, trace_msg_done, trace_msg_matches_prev;
    logic         trace_msg_accepted;
    int           n_mismatch = 0;
    int           comparisons = 0;
    sobc_overhead_ctrl u_dut (.*);
    sobc_line_model u_line (.*);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {idx[5:0], 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd      = prdata[7:0];
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input string n, input logic [7:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        `CHK(n, e, rd);
    endtask : rchk
    task automatic txchk(input string n, input sobc_tx_pos_t p, input logic [1:0] ctl,
                         input logic [7:0] e);
        @(posedge pclk);
        {tx_overhead_port_enable, tx_passthrough_select} <= ctl;
        u_line.send_tx(p, 8'h9C);
        #1;
        `CHK(n, e, tx_parallel_out);
    endtask : txchk
    task automatic kchk(input sobc_rx_pos_t p, input logic [7:0] idx, input logic [7:0] v);
        apb(1'b1, `SOBC_IDX_EVENT, 8'h03);
        repeat (2) u_line.send_rx(p, v);
        rchk("k_early", idx, 8'h00);
        u_line.send_rx(p, v);
        rchk("k_taken", idx, v);
        rchk("aps_event", `SOBC_IDX_EVENT, 8'h02);
    endtask : kchk
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rchk("tx_z1_rst", `SOBC_IDX_TX_Z1, 8'h00);
        apb(1'b1, `SOBC_IDX_Z1_Z0, 8'h5A);
        rchk("rx_z1_ro", `SOBC_IDX_Z1_Z0, 8'h00);
        apb(1'b0, 8'h3F, 8'h00);
        `CHK("unmapped_err", 1'b1, err);
        apb(1'b1, `SOBC_IDX_MODE, 8'h01);
        rchk("tx_z0_rst", `SOBC_IDX_Z1_Z0, 8'hCC);
        rchk("ais_ctl_rst", `SOBC_IDX_K1_AIS, 8'h30);
        rchk("rdi_ctl_rst", `SOBC_IDX_K2_RDI, 8'h32);
    endtask : t_regs
    task automatic t_tx;
        apb(1'b1, `SOBC_IDX_MODE, 8'h23);
        apb(1'b1, `SOBC_IDX_TX_Z1, 8'hA5);
        txchk("z1_first", SOBC_TX_Z1_FIRST, 2'b00, 8'hA5);
        txchk("z1_sts3", SOBC_TX_Z1_OTHER, 2'b00, 8'h00);
        txchk("z0_ins", SOBC_TX_Z0_OTHER, 2'b00, 8'hCC);
        tx_overhead_data <= 8'h77;
        txchk("port_over", SOBC_TX_Z1_FIRST, 2'b10, 8'h77);
        txchk("pass_over", SOBC_TX_Z1_OTHER, 2'b01, 8'h9C);
        apb(1'b1, `SOBC_IDX_DIAG, 8'h02);
        tx_b1_calc <= 8'h5A;
        txchk("b1_inv", SOBC_TX_B1, 2'b00, 8'hA5);
        `CHK("serial_msb", 1'b1, tx_serial_out);
        @(posedge pclk);
        #1;
        `CHK("serial_next", 1'b0, tx_serial_out);
        apb(1'b1, `SOBC_IDX_DIAG, 8'h04);
        txchk("force_zero", SOBC_TX_Z1_FIRST, 2'b00, 8'h00);
        `CHK("serial_zero", 1'b0, tx_serial_out);
        apb(1'b1, `SOBC_IDX_DIAG, 8'h00);
    endtask : t_tx
    task automatic t_rx;
        apb(1'b1, `SOBC_IDX_MODE, 8'h0C);
        u_line.send_rx(SOBC_RX_Z1_FIRST, 8'h3C);
        rchk("rx_z1", `SOBC_IDX_Z1_Z0, 8'h3C);
        apb(1'b1, `SOBC_IDX_EVENT, 8'h03);
        u_line.send_rx(SOBC_RX_Z1_FIRST, 8'h4D);
        rchk("z1_event", `SOBC_IDX_EVENT, 8'h01);
        `CHK("irq", 1'b1, irq);
        kchk(SOBC_RX_K1, `SOBC_IDX_K1_AIS, 8'h5A);
        kchk(SOBC_RX_K2, `SOBC_IDX_K2_RDI, 8'hA3);
    endtask : t_rx
    task automatic t_alarm;
        apb(1'b1, `SOBC_IDX_MODE, 8'h01);
        apb(1'b1, `SOBC_IDX_K1_AIS, 8'hF1);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge pclk);
            {sd_declared, sf_declared, lof_declared, los_declared} <= 4'h1 << i;
            u_line.send_rx(SOBC_RX_OTHER, 8'h12);
            #1;
            `CHK("rx_ais_fill", 8'hFF, rx_parallel_out);
            `CHK("dcc_fill", {2{i < 2}}, {rx_section_dcc_out, rx_line_dcc_out});
            `CHK("rdi_alarm", i < 2, tx_rdi_active);
        end
        u_line.send_rx(SOBC_RX_SOH, 8'h12);
        #1;
        `CHK("rx_soh_kept", 8'h12, rx_parallel_out);
        `CHK("rx_valid", 1'b1, rx_out_valid);
        @(posedge pclk);
        {sd_declared, line_ais_detected} <= 2'b01;
        #1;
        `CHK("rdi_ais", 2'b10, {tx_rdi_active, rx_ring_send_rdi});
        txchk("k2_rdi", SOBC_TX_K2, 2'b00, 8'h9E);
        apb(1'b1, `SOBC_IDX_MODE, 8'h11);
        #1;
        `CHK("rdi_ring", 2'b01, {tx_rdi_active, rx_ring_send_rdi});
        apb(1'b1, `SOBC_IDX_K1_AIS, 8'h0C);
        line_ais_detected <= 1'b0;
        trace_mismatch <= 1'b1;
        #1;
        `CHK("ais_mismatch", 1'b1, rx_ais_active);
        repeat (8)
        begin
            @(posedge pclk);
            {trace_mismatch, trace_msg_done} <= 2'b01;
            @(posedge pclk);
            trace_msg_done <= 1'b0;
        end
        #1;
        `CHK("ais_unstable", 1'b1, rx_ais_active);
        @(posedge pclk);
        trace_msg_accepted <= 1'b1;
        @(posedge pclk);
        trace_msg_accepted <= 1'b0;
        #1;
        `CHK("ais_accepted", 1'b0, rx_ais_active);
    endtask : t_alarm
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial
    begin
        repeat (5000) @(posedge pclk);
        n_mismatch++;
        end_of_test();
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, tx_b1_calc, tx_overhead_data} = '0;
        {tx_overhead_port_enable, tx_passthrough_select, rx_section_dcc_in, rx_line_dcc_in} = '0;
        {los_declared, lof_declared, sf_declared, sd_declared, line_ais_detected} = '0;
        {trace_mismatch, trace_msg_done, trace_msg_matches_prev, trace_msg_accepted} = '0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_tx();
        t_rx();
        t_alarm();
        end_of_test();
    end
endmodule : sobc_overhead_ctrl_tb
